// [sdma_regs.vh]
// register map, field positions and constants of the serial dma channel control block
// assumes a 32-bit classic wishbone slave; word-aligned byte offsets
`ifndef SDMA_REGS_VH
`define SDMA_REGS_VH
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_MASK 8'h08
`define OFS_MATCH 8'h0C
`define OFS_VECTOR 8'h10
`define OFS_SEGMENT 8'h14
`define OFS_TXPTR 8'h18
`define OFS_RXPTR 8'h1C
`define OFS_TXBUF 8'h20
`define OFS_RXBUF 8'h24
`define OFS_TXLOC 8'h28
`define OFS_RXLOC 8'h2C
`define OFS_IRQ 8'h30
// control register bits
`define CTRL_TXD 0
`define CTRL_RXD 1
`define CTRL_PAR 2
// status register bits
`define ST_TX_HOLDING_EMPTY_FLAG 0
`define ST_TX_SHIFT_EMPTY_FLAG 1
`define ST_ADDRESS_PENDING_FLAG 2
`define ST_PE 3
`define ST_FE 4
`define ST_OE 5
`define ST_TXEOB 6
`define ST_RX_END_OF_BLOCK_BIT 7
`define ST_RXRDY 8
`define ST_BRK 9
// mask register bits
`define IM_TX_DATA_INTERRUPT_MASK 0
`define IM_RX_DATA_INTERRUPT_MASK 1
`define IM_RX_END_OF_BLOCK_BIT 2
`define IM_RXA 3
`define IM_ERR 4
// vector offsets from base
`define VEC_ERR 8'h00
`define VEC_MATCH 8'h02
`define VEC_RX 8'h04
`define VEC_TX 8'h06
// reset values and other constants
`define RST_VECTOR 8'h00
`define RST_MATCH 8'h0A
`define BYTE_ZERO 8'h00
`define WORD_ZERO 16'h0000
`define WORD_ONE 16'h0001
`endif

// [sdma_chan.v]
`timescale 1ns/1ps
// one dma direction: address and counter with request issue
// assumes the memory side answers each request with a one-cycle done pulse
`include "sdma_regs.vh"
module sdma_chan (
  // clock and reset
  input wire clk,
  input wire rst,
  // software load
  input wire addr_wr,
  input wire cnt_wr,
  input wire [15:0] wdata,
  input wire regfile_mode,
  // transfer
  input wire trigger,
  input wire xfer_done,
  output wire req,
  output reg [15:0] addr_q,
  output reg [15:0] cnt_q,
  output wire eob
);
  reg pend_q;
  reg eob_q;
  assign req = pend_q;
  assign eob = eob_q;
  // byte-wide pointer and count in register-file mode
  function [15:0] wrap;
    input [15:0] v;
    input m;
    begin
      wrap = m ? {8'h00, v[7:0]} : v;
    end
  endfunction
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      addr_q <= `WORD_ZERO;
      cnt_q <= `WORD_ZERO;
      pend_q <= 1'b0;
      eob_q <= 1'b0;
    end
    else
    begin
      eob_q <= 1'b0;
      if (addr_wr)
        addr_q <= wrap(wdata, regfile_mode); // [RULE18] [RULE19]
      if (cnt_wr)
        cnt_q <= wrap(wdata, regfile_mode);
      if (trigger && cnt_q != `WORD_ZERO && !pend_q)
        pend_q <= 1'b1;
      if (xfer_done && pend_q)
      begin
        pend_q <= 1'b0;
        addr_q <= wrap(addr_q + `WORD_ONE, regfile_mode); // [RULE20]
        cnt_q <= cnt_q - `WORD_ONE; // [RULE20]
        if (cnt_q == `WORD_ONE)
          eob_q <= 1'b1; // [RULE6]
      end
    end
  end
endmodule // sdma_chan

// [sdma_vec.v]
`timescale 1ns/1ps
// interrupt vector selection from four causes
// assumes causes are levels; error has highest priority
`include "sdma_regs.vh"
module sdma_vec (
  // causes
  input wire err,
  input wire match,
  input wire rx,
  input wire tx,
  input wire [7:0] base,
  // result
  output wire any,
  output wire [7:0] vector
);
  assign any = err | match | rx | tx;
  assign vector = err ? base + `VEC_ERR : match ? base + `VEC_MATCH :
                  rx ? base + `VEC_RX : base + `VEC_TX; // [RULE16]
endmodule // sdma_vec

// [sdma_ctrl.v]
// serial dma channel control: registers, tx/rx dma steering, match and error
// assumes a classic wishbone master and a uart core giving one-cycle event pulses
// Function
// RULE1: with tx dma enabled, holding-empty raises a dma request, not an interrupt.
// RULE2: with tx dma disabled, holding-empty raises an interrupt request.
// RULE3: first character written by hand; dma feeds after it leaves.
// RULE4: software loads segment, address of second char, count minus one.
// RULE5: software clears holding-empty and shift-empty flags after first char.
// RULE6: dma stops at counter zero and signals end of block.
// RULE7: tx end-of-dma interrupt only while tx data mask set.
// RULE8: rx end-of-block request pending until mask bit cleared.
// RULE9: setting rx dma enable re-arms end-of-block and rx requests.
// RULE10: reload rx address then count; nonzero count resumes rx dma.
// RULE11: received char equal to compare value with mask set raises match interrupt.
// RULE12: on match no dma request, no rx interrupt; char blocks buffer.
// RULE13: reading rx buffer clears match and frees buffer; pending flag alone not.
// RULE14: software may block rx dma clearing rx enable and rx data mask.
// RULE15: parity (if enabled), framing, overrun flagged; software clears them.
// RULE16: vectors at base plus 0, 2, 4, 6 for error, match, rx, tx.
// RULE17: memory mode uses 16-bit pairs; counter pointer even.
// RULE18: counter pointer lsb one selects 8-bit register-file mode.
// RULE19: register-file mode: address even register, counter odd register.
// RULE20: each transfer advances address and decrements counter by one.
//
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "sdma_regs.vh"
module sdma_ctrl (
  // clock and reset
  input wire clk,
  input wire rst,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // uart transmitter
  input wire tx_holding_empty,
  input wire tx_shift_empty,
  output reg tx_load,
  output reg [7:0] tx_char,
  // uart receiver
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_parity_err,
  input wire rx_frame_err,
  input wire rx_break,
  // dma memory side
  output wire tx_dma_req,
  output wire [15:0] tx_dma_addr,
  output wire [7:0] tx_dma_segment,
  input wire tx_dma_done,
  input wire [7:0] tx_dma_data,
  output wire rx_dma_req,
  output wire [15:0] rx_dma_addr,
  output reg [7:0] rx_dma_data,
  input wire rx_dma_done,
  // interrupt to core
  output wire irq,
  output wire [7:0] irq_vector
);
  reg [2:0] ctrl_q;
  reg [9:0] status_q;
  reg [4:0] mask_q;
  reg [7:0] match_q;
  reg [7:0] vector_q;
  reg [7:0] segment_q;
  reg [15:0] tx_loc_q;
  reg [7:0] rx_buf_q;
  reg rx_full_q;
  reg hem_seen_q;
  wire acc = cyc_i & stb_i & ~ack_o;
  wire wr = acc & we_i & sel_i[0];
  wire rd = acc & ~we_i;
  wire tx_regfile = tx_loc_q[0];
  wire rx_regfile = tx_loc_q[8];
  wire tx_eob;
  wire rx_eob;
  wire [15:0] tx_cnt;
  wire [15:0] rx_cnt;
  wire rx_match = rx_valid && !rx_full_q && rx_data == match_q && mask_q[`IM_RXA]; // [RULE11]
  wire rx_ok = rx_valid && !rx_full_q && !rx_match;
  // dma request only for non-matching characters while rx dma on
  wire rx_trig = rx_ok && ctrl_q[`CTRL_RXD]; // [RULE12] [RULE9]
  // holding-empty rising edge feeds the next character
  wire hem_edge = tx_holding_empty & ~hem_seen_q;
  wire tx_trig = hem_edge && ctrl_q[`CTRL_TXD] && status_q[`ST_TX_SHIFT_EMPTY_FLAG] == 1'b0; // [RULE1] [RULE3]
  function is_ofs;
    input [7:0] a;
    input [7:0] o;
    begin
      is_ofs = (a == o);
    end
  endfunction
  // one strobe per register access keeps the decode in one place
  wire wr_ctrl = wr && is_ofs(adr_i, `OFS_CTRL);
  wire wr_status = wr && is_ofs(adr_i, `OFS_STATUS);
  wire wr_mask = wr && is_ofs(adr_i, `OFS_MASK);
  wire wr_match = wr && is_ofs(adr_i, `OFS_MATCH);
  wire wr_vector = wr && is_ofs(adr_i, `OFS_VECTOR);
  wire wr_segment = wr && is_ofs(adr_i, `OFS_SEGMENT);
  wire wr_txloc = wr && is_ofs(adr_i, `OFS_TXLOC);
  wire wr_txbuf = wr && is_ofs(adr_i, `OFS_TXBUF);
  wire wr_txptr = wr && is_ofs(adr_i, `OFS_TXPTR);
  wire wr_rxptr = wr && is_ofs(adr_i, `OFS_RXPTR);
  wire rd_rxbuf = rd && is_ofs(adr_i, `OFS_RXBUF);
  // pointer writes: lane 2 picks the count half, else the address half
  // count and address never load together, so one write cannot clobber the other
  wire ptr_cnt = sel_i[2];
  wire [15:0] ptr_wdata = ptr_cnt ? dat_i[31:16] : dat_i[15:0];
  // transmit direction
  sdma_chan u_tx (
    .clk(clk),
    .rst(rst),
    .addr_wr(wr_txptr && !ptr_cnt),
    .cnt_wr(wr_txptr && ptr_cnt),
    .wdata(ptr_wdata),
    .regfile_mode(tx_regfile),
    .trigger(tx_trig),
    .xfer_done(tx_dma_done),
    .req(tx_dma_req),
    .addr_q(tx_dma_addr),
    .cnt_q(tx_cnt),
    .eob(tx_eob)
  );
  // receive direction
  sdma_chan u_rx (
    .clk(clk),
    .rst(rst),
    .addr_wr(wr_rxptr && !ptr_cnt),
    .cnt_wr(wr_rxptr && ptr_cnt), // [RULE10]
    .wdata(ptr_wdata),
    .regfile_mode(rx_regfile),
    .trigger(rx_trig),
    .xfer_done(rx_dma_done),
    .req(rx_dma_req),
    .addr_q(rx_dma_addr),
    .cnt_q(rx_cnt),
    .eob(rx_eob)
  );
  assign tx_dma_segment = segment_q;
  // interrupt causes
  wire err_cause = (status_q[`ST_PE] | status_q[`ST_FE] | status_q[`ST_OE]) & mask_q[`IM_ERR];
  wire match_cause = (status_q[`ST_ADDRESS_PENDING_FLAG] | status_q[`ST_BRK]) & mask_q[`IM_RXA];
  wire rx_cause = (status_q[`ST_RX_END_OF_BLOCK_BIT] & mask_q[`IM_RX_END_OF_BLOCK_BIT]) // [RULE8]
    | (status_q[`ST_RXRDY] & mask_q[`IM_RX_DATA_INTERRUPT_MASK] & ~ctrl_q[`CTRL_RXD]);
  // holding-empty is an interrupt cause only without tx dma
  wire tx_cause = (status_q[`ST_TXEOB] & mask_q[`IM_TX_DATA_INTERRUPT_MASK]) // [RULE7]
    | (status_q[`ST_TX_HOLDING_EMPTY_FLAG] & mask_q[`IM_TX_DATA_INTERRUPT_MASK] & ~ctrl_q[`CTRL_TXD]); // [RULE2]
  sdma_vec u_vec (
    .err(err_cause),
    .match(match_cause),
    .rx(rx_cause),
    .tx(tx_cause),
    .base(vector_q),
    .any(irq),
    .vector(irq_vector)
  );
  // register writes and status events; set wins over clear
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= 3'h0;
      status_q <= 10'h000;
      mask_q <= 5'h00;
      match_q <= `RST_MATCH;
      vector_q <= `RST_VECTOR;
      segment_q <= `BYTE_ZERO;
      tx_loc_q <= `WORD_ZERO;
      rx_buf_q <= `BYTE_ZERO;
      rx_full_q <= 1'b0;
      hem_seen_q <= 1'b1; // pin idles high; avoids a false edge
      tx_load <= 1'b0;
      tx_char <= `BYTE_ZERO;
      rx_dma_data <= `BYTE_ZERO;
    end
    else
    begin
      hem_seen_q <= tx_holding_empty;
      tx_load <= 1'b0;
      if (wr_ctrl)
      begin
        ctrl_q <= dat_i[2:0];
        if (dat_i[`CTRL_RXD])
          mask_q[`IM_RX_END_OF_BLOCK_BIT] <= 1'b1; // [RULE9]
      end
      if (wr_mask)
        mask_q <= dat_i[4:0]; // [RULE14]
      if (wr_match)
        match_q <= dat_i[7:0];
      if (wr_vector)
        vector_q <= {dat_i[7:1], 1'b0};
      if (wr_segment)
        segment_q <= dat_i[7:0];
      if (wr_txloc)
        tx_loc_q <= dat_i[15:0]; // [RULE17] [RULE18]
      // first character by hand
      if (wr_txbuf)
      begin
        tx_load <= 1'b1; // [RULE3]
        tx_char <= dat_i[7:0];
      end
      else if (tx_dma_done && tx_dma_req)
      begin
        tx_load <= 1'b1;
        tx_char <= tx_dma_data;
      end
      // write-one-to-clear status
      if (wr_status)
        status_q <= status_q & ~dat_i[9:0]; // [RULE5] [RULE15]
      if (hem_edge)
        status_q[`ST_TX_HOLDING_EMPTY_FLAG] <= 1'b1;
      if (tx_shift_empty)
        status_q[`ST_TX_SHIFT_EMPTY_FLAG] <= 1'b1;
      if (tx_eob)
        status_q[`ST_TXEOB] <= 1'b1; // [RULE6]
      if (rx_eob)
        status_q[`ST_RX_END_OF_BLOCK_BIT] <= 1'b1; // [RULE6]
      // clearing the mask bit withdraws the eob request
      if (wr_mask && !dat_i[`IM_RX_END_OF_BLOCK_BIT])
        status_q[`ST_RX_END_OF_BLOCK_BIT] <= rx_eob; // [RULE8]
      if (rx_valid && rx_parity_err && ctrl_q[`CTRL_PAR])
        status_q[`ST_PE] <= 1'b1; // [RULE15]
      if (rx_valid && rx_frame_err)
        status_q[`ST_FE] <= 1'b1; // [RULE15]
      if (rx_valid && rx_full_q)
        status_q[`ST_OE] <= 1'b1; // [RULE15]
      if (rx_break)
        status_q[`ST_BRK] <= 1'b1;
      // character parked in buffer until read
      if (rx_match)
      begin
        status_q[`ST_ADDRESS_PENDING_FLAG] <= 1'b1; // [RULE11]
        rx_buf_q <= rx_data;
        rx_full_q <= 1'b1; // [RULE12]
      end
      else if (rx_ok)
      begin
        rx_dma_data <= rx_data;
        rx_buf_q <= rx_data;
        if (!ctrl_q[`CTRL_RXD])
        begin
          rx_full_q <= 1'b1;
          status_q[`ST_RXRDY] <= 1'b1;
        end
      end
      else if (rd_rxbuf)
      begin
        rx_full_q <= 1'b0; // [RULE13]
        status_q[`ST_ADDRESS_PENDING_FLAG] <= 1'b0; // [RULE13]
        status_q[`ST_RXRDY] <= 1'b0;
      end
    end
  end
  // read data and ack, one wait-free cycle
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_o <= acc;
      dat_o <= 32'h00000000;
      if (rd)
      begin
        case (adr_i)
          `OFS_CTRL: dat_o <= {29'h00000000, ctrl_q};
          `OFS_STATUS: dat_o <= {22'h000000, status_q};
          `OFS_MASK: dat_o <= {27'h0000000, mask_q};
          `OFS_MATCH: dat_o <= {24'h000000, match_q};
          `OFS_VECTOR: dat_o <= {24'h000000, vector_q};
          `OFS_SEGMENT: dat_o <= {24'h000000, segment_q};
          `OFS_TXPTR: dat_o <= {tx_cnt, tx_dma_addr};
          `OFS_RXPTR: dat_o <= {rx_cnt, rx_dma_addr};
          `OFS_RXBUF: dat_o <= {24'h000000, rx_buf_q};
          `OFS_TXLOC: dat_o <= {16'h0000, tx_loc_q};
          `OFS_IRQ: dat_o <= {23'h000000, irq, irq_vector};
          default: dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // sdma_ctrl

// [sdma_ctrl_checker.sv]
`timescale 1ns/1ps
// assertions on the sdma_ctrl bus handshake and dma request ports
// assumes one clock domain, async active-high reset
module sdma_ctrl_checker (
  // clock and reset
  input wire clk,
  input wire rst,
  // bus
  input wire cyc_i,
  input wire stb_i,
  input wire ack_o,
  // dma
  input wire tx_dma_req,
  input wire tx_dma_done,
  input wire [15:0] tx_dma_addr,
  input wire rx_dma_req,
  input wire rx_dma_done,
  input wire [15:0] rx_dma_addr
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence taken;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence tx_step;
    tx_dma_req && tx_dma_done;
  endsequence
  sequence rx_step;
    rx_dma_req && rx_dma_done;
  endsequence
  AST_ACK_TAKEN: assert property (taken |=> ack_o) else $error("ack late");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack too long");
  AST_ACK_CAUSE: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i)) else $error("ack unasked");
  AST_TX_HOLD: assert property (tx_dma_req && !tx_dma_done |=> tx_dma_req) else $error("tx req dropped");
  AST_RX_HOLD: assert property (rx_dma_req && !rx_dma_done |=> rx_dma_req) else $error("rx req dropped");
  AST_TX_STEP: assert property (tx_step |=> tx_dma_addr == $past(tx_dma_addr) + 16'h0001)
    else $error("tx address step");
  AST_RX_STEP: assert property (rx_step |=> rx_dma_addr == $past(rx_dma_addr) + 16'h0001)
    else $error("rx address step");
  AST_TX_WAIT: assert property (tx_dma_req && !tx_dma_done |=> $stable(tx_dma_addr)) else $error("tx addr moved");
  AST_RX_WAIT: assert property (rx_dma_req && !rx_dma_done |=> $stable(rx_dma_addr)) else $error("rx addr moved");
endmodule // sdma_ctrl_checker

bind sdma_ctrl sdma_ctrl_checker chk_i (.*);

// [far_side.sv]
`timescale 1ns/1ps
// far side of sdma_ctrl: byte memory for both dma channels and a transmitter
// assumes requests are levels held until the done pulse
module far_side (
  // clock and reset
  input wire clk,
  input wire rst,
  // dma memory side
  input wire [3:0] lat,
  input wire tx_dma_req,
  input wire [15:0] tx_dma_addr,
  output reg tx_dma_done,
  output wire [7:0] tx_dma_data,
  input wire rx_dma_req,
  input wire [15:0] rx_dma_addr,
  input wire [7:0] rx_dma_data,
  output reg rx_dma_done,
  // transmitter
  input wire tx_load,
  input wire [7:0] tx_char,
  output reg tx_holding_empty,
  output reg tx_shift_empty,
  // observation
  output reg [7:0] sent_n,
  output reg [7:0] sent_c,
  output reg [7:0] mem_n,
  output reg [15:0] mem_a,
  output reg [7:0] mem_d
);
  reg [3:0] wait_q;
  reg [4:0] bit_q;
  wire go = (tx_dma_req || rx_dma_req) && !tx_dma_done && !rx_dma_done;
  wire [7:0] byte_val = tx_dma_addr[7:0] + 8'h30;
  // valid only with done; inverse otherwise so a stale sample shows
  assign tx_dma_data = tx_dma_done ? byte_val : ~byte_val;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {tx_dma_done, rx_dma_done, wait_q, bit_q} <= 11'h000;
      {tx_holding_empty, tx_shift_empty} <= 2'b11;
      {sent_n, sent_c, mem_n, mem_a, mem_d} <= 48'h0;
    end
    else
    begin
      tx_dma_done <= go && wait_q == lat && tx_dma_req;
      rx_dma_done <= go && wait_q == lat && !tx_dma_req;
      if (go)
        wait_q <= (wait_q == lat) ? 4'h0 : wait_q + 4'h1;
      if (go && wait_q == lat && !tx_dma_req)
        {mem_n, mem_a, mem_d} <= {mem_n + 8'h01, rx_dma_addr, rx_dma_data};
      // holding frees midway so a fed char lands before shift empties
      if (tx_load)
      begin
        {tx_holding_empty, tx_shift_empty, bit_q} <= {2'b00, 5'h14};
        {sent_n, sent_c} <= {sent_n + 8'h01, tx_char};
      end
      else if (bit_q != 5'h00)
      begin
        bit_q <= bit_q - 5'h01;
        if (bit_q == 5'h0B)
          tx_holding_empty <= 1'b1;
        if (bit_q == 5'h01)
          tx_shift_empty <= 1'b1;
      end
    end
  end
endmodule // far_side

// [tb.sv]
`timescale 1ns/1ps
// testbench for sdma_ctrl with far_side as memory and transmitter
// assumes 40 MHz clock and classic wishbone single cycles
`include "sdma_regs.vh"
module tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  reg [7:0] adr_i = 8'h00;
  reg [3:0] sel_i = 4'h0;
  reg [31:0] dat_i = 32'h0;
  reg rx_valid = 1'b0, rx_parity_err = 1'b0, rx_frame_err = 1'b0, rx_break = 1'b0;
  reg [7:0] rx_data = 8'h00;
  reg [3:0] lat = 4'h1;
  wire [31:0] dat_o;
  wire ack_o, tx_holding_empty, tx_shift_empty, tx_load, tx_dma_req, tx_dma_done, rx_dma_req, rx_dma_done, irq;
  wire [7:0] tx_char, tx_dma_segment, tx_dma_data, rx_dma_data, irq_vector, sent_n, sent_c, mem_n, mem_d;
  wire [15:0] tx_dma_addr, rx_dma_addr, mem_a;
  reg [31:0] q;
  integer err_count = 0;
  integer checks_done = 0;
  always #12.5 clk = ~clk;
  sdma_ctrl uut (.*);
  far_side fs (.*);
  task chk(input [31:0] g, input [31:0] e);
  begin
    checks_done = checks_done + 1;
    if (g !== e)
    begin
      err_count = err_count + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  end
  endtask
  task iv(input [8:0] e);
  begin
    chk({23'h0, irq, irq_vector & {8{e[8]}}}, {23'h0, e});
  end
  endtask
  task wb(input w, input [7:0] a, input [3:0] s, input [31:0] d);
  begin
    @(posedge clk);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, d};
    @(posedge clk);
    while (ack_o !== 1'b1)
      @(posedge clk);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  end
  endtask
  task rxc(input [7:0] c, input [1:0] e);
  begin
    @(posedge clk);
    {rx_valid, rx_parity_err, rx_frame_err, rx_data} <= {1'b1, e, c};
    @(posedge clk);
    {rx_valid, rx_parity_err, rx_frame_err} <= 3'b000;
    repeat (10) @(posedge clk);
  end
  endtask
  task t_reg;
  begin
    wb(1'b0, `OFS_MATCH, 4'h1, 32'h0);
    chk(q & 32'hFF, 32'h0A);
    wb(1'b1, `OFS_VECTOR, 4'h1, 32'h50);
    wb(1'b0, `OFS_VECTOR, 4'h1, 32'h0);
    chk(q & 32'hFF, 32'h50);
    wb(1'b0, 8'hFC, 4'h1, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, `OFS_TXLOC, 4'h1, 32'h0001);
    wb(1'b1, `OFS_TXPTR, 4'h1, 32'h1234);
    wb(1'b0, `OFS_TXPTR, 4'h1, 32'h0);
    chk(q, 32'h00000034);
    wb(1'b1, `OFS_TXLOC, 4'h1, 32'h0000);
    $display("register test done");
  end
  endtask
  task t_txint;
  begin
    wb(1'b1, `OFS_MASK, 4'h1, 32'h1);
    wb(1'b1, `OFS_TXBUF, 4'h1, 32'h55);
    while (tx_shift_empty !== 1'b0 || tx_holding_empty !== 1'b1)
      @(posedge clk);
    repeat (2) @(posedge clk);
    chk({16'h0000, sent_c, 7'h00, tx_dma_req}, 32'h00005500);
    iv(9'h156);
    while (tx_shift_empty !== 1'b1)
      @(posedge clk);
    wb(1'b1, `OFS_STATUS, 4'h1, 32'h3);
    $display("tx interrupt test done");
  end
  endtask
  task t_txdma;
  begin
    wb(1'b1, `OFS_SEGMENT, 4'h1, 32'h07);
    wb(1'b1, `OFS_TXPTR, 4'h1, 32'h0101);
    wb(1'b1, `OFS_TXPTR, 4'h5, 32'h00020000);
    wb(1'b1, `OFS_CTRL, 4'h1, 32'h1);
    wb(1'b1, `OFS_TXBUF, 4'h1, 32'h41);
    wb(1'b1, `OFS_STATUS, 4'h1, 32'h3);
    while (sent_n !== 8'h04)
      @(posedge clk);
    repeat (4) @(posedge clk);
    chk({tx_dma_segment, sent_c, tx_dma_addr}, 32'h07320103);
    wb(1'b0, `OFS_STATUS, 4'h1, 32'h0);
    chk({q[30:0] & 31'h00000040, tx_dma_req}, 32'h00000080);
    iv(9'h156);
    wb(1'b1, `OFS_MASK, 4'h1, 32'h0);
    iv(9'h000);
    $display("tx dma test done");
  end
  endtask
  task t_rx;
  begin
    lat <= 4'h6;
    wb(1'b1, `OFS_CTRL, 4'h1, 32'h2);
    wb(1'b1, `OFS_RXPTR, 4'h1, 32'h0200);
    wb(1'b1, `OFS_RXPTR, 4'h5, 32'h00020000);
    rxc(8'h11, 2'b00);
    rxc(8'h22, 2'b00);
    chk({mem_n, mem_a, mem_d}, 32'h02020122);
    wb(1'b0, `OFS_STATUS, 4'h1, 32'h0);
    chk({q[30:0] & 31'h00000080, rx_dma_req}, 32'h00000100);
    iv(9'h154);
    wb(1'b1, `OFS_MASK, 4'h1, 32'h0);
    iv(9'h000);
    $display("rx dma test done");
  end
  endtask
  task t_match;
  begin
    wb(1'b1, `OFS_MASK, 4'h1, 32'h8);
    wb(1'b1, `OFS_CTRL, 4'h1, 32'h2);
    wb(1'b1, `OFS_RXPTR, 4'h1, 32'h0300);
    wb(1'b1, `OFS_RXPTR, 4'h5, 32'h00040000);
    rxc(8'h0A, 2'b00);
    iv(9'h152);
    wb(1'b0, `OFS_STATUS, 4'h1, 32'h0);
    chk({q[23:0] & 24'h000004, mem_n}, 32'h00000402);
    wb(1'b1, `OFS_STATUS, 4'h1, 32'h4);
    rxc(8'h33, 2'b00);
    chk({23'h000000, mem_n, rx_dma_req}, 32'h00000004);
    wb(1'b1, `OFS_CTRL, 4'h1, 32'h0);
    wb(1'b0, `OFS_RXBUF, 4'h1, 32'h0);
    chk(q & 32'hFF, 32'h0A);
    iv(9'h000);
    wb(1'b1, `OFS_CTRL, 4'h1, 32'h2);
    rxc(8'h44, 2'b00);
    chk({mem_n, mem_a, mem_d}, 32'h03030044);
    $display("match test done");
  end
  endtask
  task t_err;
  begin
    wb(1'b1, `OFS_MASK, 4'h1, 32'h10);
    rxc(8'h66, 2'b11);
    wb(1'b0, `OFS_STATUS, 4'h1, 32'h0);
    chk(q & 32'h18, 32'h10);
    iv(9'h150);
    wb(1'b1, `OFS_STATUS, 4'h1, 32'h38);
    iv(9'h000);
    wb(1'b1, `OFS_CTRL, 4'h1, 32'h6);
    rxc(8'h67, 2'b10);
    wb(1'b0, `OFS_STATUS, 4'h1, 32'h0);
    chk(q & 32'h18, 32'h08);
    iv(9'h150);
    wb(1'b1, `OFS_STATUS, 4'h1, 32'h38);
    iv(9'h000);
    wb(1'b1, `OFS_MASK, 4'h1, 32'h8);
    @(posedge clk) rx_break <= 1'b1;
    @(posedge clk) rx_break <= 1'b0;
    @(posedge clk);
    iv(9'h152);
    wb(1'b1, `OFS_STATUS, 4'h3, 32'h200);
    iv(9'h000);
    $display("error test done");
  end
  endtask
  task test_done;
  begin
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reg;
    t_txint;
    t_txdma;
    t_rx;
    t_match;
    t_err;
    test_done;
  end
  // whole run is a few hundred cycles; this limit of 12000 cycles is dozens of times that
  initial
  begin
    #300000;
    err_count = err_count + 1;
    test_done;
  end
endmodule // tb
